// ---- tb/boot_eeprom_model.sv ----
// Purpose: behavioural boot eeprom on the two-wire bus
// Assumes: pull-ups on both wires; scl low phases last over 10 ns
// Notes:   i_refuse withholds every ack to exercise the abandon path
module boot_eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  // bus
  input  wire logic i_scl,
  input  wire logic i_sda,
  output      logic o_sda_oe_n,
  // test control
  input  wire logic i_refuse
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [4] = '{8'h3c, 8'ha5, 8'h01, 8'hf0};
  logic [7:0] rx_log [3];
  logic [7:0] sh;
  logic [1:0] ptr;
  int         bitn;
  int         nrx = 0;
  logic       act = 1'b0;
  logic       is_addr;
  logic       rd;
  logic       tx = 1'b0;

  initial o_sda_oe_n = 1'b1;

  // judged 1 ns late so an sda edge landing with scl falling is neither start nor stop
  always @(negedge i_sda) begin
    #1;
    if (i_scl && !i_sda) begin
      if (!act) nrx = 0;
      act = 1'b1;
      is_addr = 1'b1;
      tx = 1'b0;
      bitn = -1;
    end
  end
  always @(posedge i_sda) begin
    #1;
    if (i_scl && i_sda) act = 1'b0;
  end
  always @(posedge i_scl) begin
    if (act && !tx && bitn >= 0 && bitn < 8) sh = {sh[6:0], i_sda};
    else if (act && tx && bitn == 8 && i_sda) act = 1'b0;
  end
  always @(negedge i_scl) begin
    if (act) begin
      #10;
      if (bitn < 8) bitn = bitn + 1;
      else begin
        bitn = 0;
        if (!tx && nrx < 3) rx_log[nrx] = sh;
        if (!tx) nrx = nrx + 1;
        if (is_addr) rd = sh[0];
        else if (!rd) ptr = sh[1:0];
        is_addr = 1'b0;
        tx = rd;
        if (tx) sh = mem[ptr];
        if (tx) ptr = ptr + 2'h1;
      end
      if (bitn == 8) o_sda_oe_n = tx | i_refuse | (is_addr & (sh[7:1] != DEV_ADDR));
      else o_sda_oe_n = (tx && bitn >= 0) ? sh[7 - bitn] : 1'b1;
    end
  end
endmodule : boot_eeprom_model

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for boot loader and sync serial port
// Assumes: boot quarter cut to 4 clocks and four boot bytes
// Notes:   strobe rests low between commands
module tb_top
  import serial_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] DEV = 7'h50;
  logic       clk, rst, din, strobe, deb_off, refuse, sda_v, sda_oe_n, scl_v, scl_oe_n;
  logic       eep_oe_n, dout, dout_oe_n, take, done, fail, last_seen;
  logic [2:0] boot_id;
  logic [7:0] ctrl_rx, raddr, rdata, rb, rbo, last_data;
  ctrl_byte_t ctrl_tx;
  wire        sda, scl;
  int         fails, n_compared, cycles, n_valid, n_last, n_take;

  // open-drain wires with pull-ups
  assign sda = (sda_oe_n | sda_v) & eep_oe_n;
  assign scl = scl_oe_n | scl_v;

  serial_config_interfaces #(.QTR_CYC(4), .BOOT_BYTES(4), .EEPROM_ADDR(DEV)) uut (
    .i_clk(clk), .i_reset(rst), .i_twi_sda(sda), .o_twi_sda(sda_v),
    .o_twi_sda_oe_n(sda_oe_n), .i_twi_scl(scl), .o_twi_scl(scl_v),
    .o_twi_scl_oe_n(scl_oe_n), .i_strobe(strobe), .i_serial_data_in(din),
    .o_serial_data_out(dout), .o_serial_data_out_oe_n(dout_oe_n), .i_boot_id(boot_id),
    .i_debounce_off(deb_off), .o_ctrl_tx(ctrl_tx), .i_ctrl_rx_data(ctrl_rx),
    .o_ctrl_rx_take(take), .o_boot_done(done), .o_boot_fail(fail),
    .i_cfg_raddr(raddr), .o_cfg_rdata(rdata));
  boot_eeprom_model #(.DEV_ADDR(DEV)) eep (
    .i_scl(scl), .i_sda(sda), .o_sda_oe_n(eep_oe_n), .i_refuse(refuse));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (ctrl_tx.valid === 1'b1) begin
      n_valid <= n_valid + 1;
      n_last <= n_last + int'(ctrl_tx.last);
      last_seen <= ctrl_tx.last;
      last_data <= ctrl_tx.data;
    end
    if (take === 1'b1) n_take <= n_take + 1;
    if (cycles == 30000) begin
      fails = fails + 1;
      $display("unexpected at %0t: run hung", $time);
      stop_test;
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask : chk_bit
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  // pc side: data set before strobe rise, output sampled just before the fall
  task automatic ssi_bit(input logic at_rise, input logic at_fall);
    din = at_rise;
    #8 strobe = 1'b1;
    #16 din = at_fall;
    #16 rb = {rb[6:0], dout};
    rbo = {rbo[6:0], dout_oe_n};
    strobe = 1'b0;
    #24;
  endtask : ssi_bit
  task automatic ssi_cmd(input logic [2:0] id, input logic [2:0] port, input logic rw);
    logic [6:0] h;
    h = {id, port, rw};
    ssi_bit(1'b1, 1'b0);
    for (int i = 6; i >= 0; i--) ssi_bit(h[i], h[i]);
  endtask : ssi_cmd
  task automatic ssi_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) ssi_bit(d[i], d[i]);
  endtask : ssi_byte
  task automatic ssi_write(input logic [2:0] id, port, input logic [7:0] d, input logic [1:0] e);
    ssi_cmd(id, port, 1'b0);
    ssi_byte(d);
    ssi_bit(e[1], e[1]);
    ssi_bit(e[0], e[0]);
    #40;
  endtask : ssi_write
  task automatic ssi_read(input logic [2:0] id, port, input logic [7:0] exp, exp_oe);
    ssi_cmd(id, port, 1'b1);
    ssi_byte(8'hff);
    #40;
    chk_byte(rb, exp, "read data");
    chk_byte(rbo, exp_oe, "read drive");
    chk_bit(dout_oe_n, 1'b1, "read release");
  endtask : ssi_read
  task automatic chk_cfg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk) raddr = a;
    repeat (2) @(negedge clk);
    chk_byte(rdata, exp, "cfg store");
  endtask : chk_cfg

  task automatic t_boot(input logic no_ack);
    refuse = no_ack;
    @(negedge clk) rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    for (int n = 0; n < 3000 && done !== 1'b1; n++) @(negedge clk);
    chk_bit(done, 1'b1, "boot done");
    chk_bit(fail, no_ack, "boot fail");
    chk_bit(sda & scl, 1'b1, "bus idle");
    chk_byte(eep.rx_log[0], {DEV, 1'b0}, "write address");
  endtask : t_boot
  task automatic t_boot_ok;
    t_boot(1'b0);
    chk_byte(eep.rx_log[1], BOOT_WORD_ADDR, "word address");
    chk_byte(eep.rx_log[2], {DEV, 1'b1}, "read address");
    for (int n = 0; n < 4; n++) chk_cfg(8'(n), eep.mem[n]);
  endtask : t_boot_ok
  task automatic t_cfg;
    ssi_write(3'h5, PORT_INDEX, 8'h02, 2'h3);
    ssi_write(3'h5, PORT_DATA, 8'h5a, 2'h3);
    ssi_read(3'h5, PORT_DATA, 8'h5a, 8'h00);
    ssi_read(3'h5, 3'h4, RD_UNMAPPED, 8'h00);
    chk_cfg(8'h02, 8'h5a);
  endtask : t_cfg
  task automatic t_refuse;
    ssi_write(3'h2, PORT_DATA, 8'hc3, 2'h3);
    ssi_read(3'h2, PORT_DATA, 8'hff, 8'hff);
    ssi_write(3'h5, PORT_DATA, 8'hc3, 2'h0);
    ssi_cmd(3'h5, PORT_DATA, 1'b0);
    for (int i = 0; i < 4; i++) ssi_bit(1'b1, 1'b1);
    ssi_bit(1'b0, 1'b1);
    chk_cfg(8'h02, 8'h5a);
    ssi_write(3'h5, PORT_DATA, 8'h96, 2'h3);
    ssi_cmd(3'h5, PORT_DATA, 1'b1);
    for (int i = 0; i < 3; i++) ssi_bit(1'b1, 1'b1);
    ssi_bit(1'b0, 1'b1);
    for (int i = 0; i < 4; i++) ssi_bit(1'b1, 1'b1);
    chk_byte(rb, 8'h96, "read past abort");
    #40;
  endtask : t_refuse
  task automatic t_ctrl;
    for (int i = 0; i < 40; i++) ssi_write(3'h5, PORT_CTRL, 8'(i), 2'h3);
    chk_byte(8'(n_valid), 8'h28, "ctrl bytes");
    chk_byte(8'(n_last), 8'h01, "last flags");
    chk_bit(last_seen, 1'b1, "last on final");
    chk_byte(last_data, 8'h27, "ctrl data");
    ctrl_rx = 8'h7e;
    ssi_read(3'h5, PORT_CTRL, 8'h7e, 8'h00);
    chk_byte(8'(n_take), 8'h01, "ctrl take");
  endtask : t_ctrl
  task automatic t_deb;
    deb_off = 1'b1;
    ssi_write(3'h5, PORT_DATA, 8'h69, 2'h3);
    ssi_read(3'h5, PORT_DATA, 8'h69, 8'h00);
    deb_off = 1'b0;
  endtask : t_deb

  initial begin
    {rst, din, strobe, deb_off, refuse} = 5'h11;
    boot_id = 3'h5;
    {ctrl_rx, raddr} = 16'h0000;
    {fails, n_compared, cycles, n_valid, n_last, n_take} = '0;
    t_boot(1'b1);
    t_boot_ok;
    t_cfg;
    t_refuse;
    t_ctrl;
    t_deb;
    stop_test;
  end
endmodule : tb_top

// ---- verilog/serial_cfg_pkg.sv ----
// Purpose: constants and types for the boot loader and sync serial port
// Assumes: 200 MHz system clock, boot bus at 50 kbit/s
// Notes:   all counts are derived from times at the clock rate
//
// What this block does
// - at boot the block masters the two-wire bus and reads an eeprom
// - two-wire bytes are 8 bits, clocked by the block at 50 kbit/s
// - start: sda falls while scl high; bus busy from then
// - sda changes only while scl low, except start and stop
// - idle two-wire bus leaves both lines high
// - first byte holds 7-bit eeprom address, eighth bit gives read or write
// - ack clock after every byte; transmitter releases sda, receiver pulls low except on the last boot byte
// - missing eeprom ack makes the block send stop and give up
// - bytes after the address are data, msb first, each acknowledged except the last boot byte
// - stop: sda rises while scl high; bus free afterwards
// - sync serial port: pc masters, block is slave, no ack bits
// - strobe input is debounced, and debounce can be switched off
// - 3-bit identity caught at bootstrap lets eight blocks share the port
// - address, command, write data in on serial_data_in; reads on serial_data_out
// - abort pulse ends writes anytime, reads only before the read command
// - start: data in high at strobe rise, low at next fall
// - abort: data in low at strobe rise, high at next fall
// - every configuration register is writable and readable over the port
// - control frames of at most 40 bytes pass through port address 111
// - config access writes index at 000b, then data at 010b
package serial_cfg_pkg;

  localparam int CLK_NS       = 5;
  localparam int TWI_BIT_NS   = 20000;
  localparam int TWI_QTR_CYC  = TWI_BIT_NS / (4 * CLK_NS);
  localparam int DEBOUNCE_NS  = 10;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;

  localparam int TWI_ACK_BIT    = 8;
  localparam int SSI_HDR_BITS   = 7;
  localparam int SSI_DATA_BITS  = 8;
  localparam int SSI_END_BITS   = 2;
  localparam int CTRL_FRAME_MAX = 40;

  localparam logic [2:0] PORT_INDEX     = 3'h0;
  localparam logic [2:0] PORT_DATA      = 3'h2;
  localparam logic [2:0] PORT_CTRL      = 3'h7;
  localparam logic [7:0] BOOT_WORD_ADDR = 8'h00;
  localparam logic [7:0] RD_UNMAPPED    = 8'h00;
  localparam logic [7:0] INDEX_RESET    = 8'h00;

  typedef enum logic [2:0] {
    TWI_IDLE  = 3'b000,
    TWI_START = 3'b001,
    TWI_BYTE  = 3'b011,
    TWI_STOP  = 3'b010,
    TWI_DONE  = 3'b110
  } twi_state_t;

  typedef enum logic [1:0] {
    SEQ_ADDR_WR = 2'b00,
    SEQ_WORD    = 2'b01,
    SEQ_ADDR_RD = 2'b11,
    SEQ_DATA    = 2'b10
  } twi_seq_t;

  typedef enum logic [2:0] {
    SSI_IDLE  = 3'b000,
    SSI_HDR   = 3'b001,
    SSI_WDATA = 3'b011,
    SSI_WEND  = 3'b010,
    SSI_RDATA = 3'b110
  } ssi_state_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } ctrl_byte_t;

endpackage : serial_cfg_pkg

// ---- verilog/serial_config_interfaces.sv ----
// Purpose: eeprom boot loader (two-wire master) and sync serial port slave
// Assumes: all pins asynchronous to i_clk; strobe period well above 8 clocks
// Notes:   open-drain twi pins: *_oe_n low pulls the line low, high releases it; o_serial_data_out drives its value while o_serial_data_out_oe_n is low
module serial_config_interfaces
  import serial_cfg_pkg::*;
#(
  parameter int         CFG_AW      = 8,
  parameter int         BOOT_BYTES  = 256,
  parameter int         QTR_CYC     = TWI_QTR_CYC,
  parameter int         DEB_CYC     = DEBOUNCE_CYC,
  parameter logic [6:0] EEPROM_ADDR = 7'h50
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  // two-wire boot bus
  input  wire logic              i_twi_sda,
  output      logic              o_twi_sda,
  output      logic              o_twi_sda_oe_n,
  input  wire logic              i_twi_scl,
  output      logic              o_twi_scl,
  output      logic              o_twi_scl_oe_n,
  // sync serial port
  input  wire logic              i_strobe,
  input  wire logic              i_serial_data_in,
  output      logic              o_serial_data_out,
  output      logic              o_serial_data_out_oe_n,
  // straps
  input  wire logic [2:0]        i_boot_id,
  input  wire logic              i_debounce_off,
  // management processor control frames
  output      ctrl_byte_t        o_ctrl_tx,
  input  wire logic [7:0]        i_ctrl_rx_data,
  output      logic              o_ctrl_rx_take,
  // status and core-side config read
  output      logic              o_boot_done,
  output      logic              o_boot_fail,
  input  wire logic [CFG_AW-1:0] i_cfg_raddr,
  output      logic [7:0]        o_cfg_rdata
);

  localparam int QW = $clog2(QTR_CYC) + 1;
  localparam int DW = $clog2(DEB_CYC) + 1;

  // pin synchronisers: {id[2:0], debounce_off, data_in, strobe, scl, sda}
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic       sda_s;
  logic       scl_s;
  logic       str_s;
  logic       din_s;
  logic       dbo_s;

  always_ff @(posedge i_clk) begin
    sync1_ff <= {i_boot_id, i_debounce_off, i_serial_data_in, i_strobe, i_twi_scl, i_twi_sda};
    sync2_ff <= sync1_ff;
  end

  assign sda_s = sync2_ff[0];
  assign scl_s = sync2_ff[1];
  assign str_s = sync2_ff[2];
  assign din_s = sync2_ff[3];
  assign dbo_s = sync2_ff[4];

  // identity strap caught while reset is held
  logic [2:0] id_ff;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      id_ff <= sync2_ff[7:5];
    end
  end

  // ---------------- two-wire boot loader ----------------
  logic [7:0]        cfg_mem [2**CFG_AW];
  twi_state_t        twi_st_ff, nxt_twi_st;
  twi_seq_t          seq_ff, nxt_seq;
  logic [1:0]        ph_ff, nxt_ph;
  logic [QW-1:0]     qcnt_ff, nxt_qcnt;
  logic [3:0]        bit_ff, nxt_bit;
  logic [7:0]        tsh_ff, nxt_tsh;
  logic              samp_ff, nxt_samp;
  logic [CFG_AW-1:0] bcnt_ff, nxt_bcnt;
  logic              sda_oe_n_ff, nxt_sda_oe_n;
  logic              scl_oe_n_ff, nxt_scl_oe_n;
  logic              done_ff, nxt_done;
  logic              fail_ff, nxt_fail;
  logic              boot_we;
  logic              tick;
  logic              tx;
  logic              last;

  always_comb begin
    nxt_twi_st   = twi_st_ff;
    nxt_seq      = seq_ff;
    nxt_ph       = ph_ff;
    nxt_qcnt     = '0;
    nxt_bit      = bit_ff;
    nxt_tsh      = tsh_ff;
    nxt_samp     = samp_ff;
    nxt_bcnt     = bcnt_ff;
    nxt_sda_oe_n = 1'b1;
    nxt_scl_oe_n = 1'b1;
    nxt_done     = done_ff;
    nxt_fail     = fail_ff;
    boot_we      = 1'b0;
    tick         = (qcnt_ff == QW'(QTR_CYC - 1));
    tx           = (seq_ff != SEQ_DATA);
    last         = (bcnt_ff == CFG_AW'(BOOT_BYTES - 1));
    // four quarter phases per bit set the 50 kbit/s rate
    if (twi_st_ff == TWI_START || twi_st_ff == TWI_BYTE || twi_st_ff == TWI_STOP) begin
      nxt_qcnt = tick ? '0 : qcnt_ff + 1'b1;
      if (tick) begin
        nxt_ph = ph_ff + 2'd1;
      end
    end
    case (twi_st_ff)
      TWI_IDLE: begin
        // wait for a free bus before claiming it
        if (sda_s && scl_s) begin
          nxt_twi_st = TWI_START;
          nxt_ph     = 2'd0;
          nxt_seq    = SEQ_ADDR_WR;
        end
      end
      TWI_START: begin
        nxt_scl_oe_n = (ph_ff == 2'd1) || (ph_ff == 2'd2);
        nxt_sda_oe_n = (ph_ff < 2'd2);
        if (tick && ph_ff == 2'd3) begin
          nxt_twi_st = TWI_BYTE;
          nxt_bit    = 4'd0;
          nxt_tsh    = {EEPROM_ADDR, seq_ff == SEQ_ADDR_RD};
        end
      end
      TWI_BYTE: begin
        nxt_scl_oe_n = ph_ff[1];
        if (bit_ff < 4'(TWI_ACK_BIT)) begin
          nxt_sda_oe_n = tx ? tsh_ff[7] : 1'b1;
        end else begin
          nxt_sda_oe_n = tx ? 1'b1 : last;
        end
        if (tick && ph_ff == 2'd2) begin
          nxt_samp = sda_s;
        end
        if (tick && ph_ff == 2'd3) begin
          if (bit_ff < 4'(TWI_ACK_BIT)) begin
            nxt_tsh = {tsh_ff[6:0], samp_ff};
            nxt_bit = bit_ff + 4'd1;
          end else begin
            nxt_bit = 4'd0;
            if (tx && samp_ff) begin
              nxt_twi_st = TWI_STOP;
              nxt_fail   = 1'b1;
            end else if (tx) begin
              case (seq_ff)
                SEQ_ADDR_WR: begin
                  nxt_seq = SEQ_WORD;
                  nxt_tsh = BOOT_WORD_ADDR;
                end
                SEQ_WORD: begin
                  nxt_seq    = SEQ_ADDR_RD;
                  nxt_twi_st = TWI_START;
                end
                default: begin
                  nxt_seq = SEQ_DATA;
                end
              endcase
            end else begin
              boot_we  = 1'b1;
              nxt_bcnt = bcnt_ff + 1'b1;
              if (last) begin
                nxt_twi_st = TWI_STOP;
              end
            end
          end
        end
      end
      TWI_STOP: begin
        nxt_scl_oe_n = (ph_ff != 2'd0);
        nxt_sda_oe_n = ph_ff[1];
        if (tick && ph_ff == 2'd3) begin
          nxt_twi_st = TWI_DONE;
          nxt_done   = 1'b1;
        end
      end
      TWI_DONE: begin
        nxt_done = 1'b1;
      end
      default: begin
        nxt_twi_st = TWI_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      twi_st_ff   <= TWI_IDLE;
      seq_ff      <= SEQ_ADDR_WR;
      ph_ff       <= 2'd0;
      qcnt_ff     <= '0;
      bit_ff      <= 4'd0;
      tsh_ff      <= 8'h00;
      samp_ff     <= 1'b1;
      bcnt_ff     <= '0;
      sda_oe_n_ff <= 1'b1;
      scl_oe_n_ff <= 1'b1;
      done_ff     <= 1'b0;
      fail_ff     <= 1'b0;
    end else begin
      twi_st_ff   <= nxt_twi_st;
      seq_ff      <= nxt_seq;
      ph_ff       <= nxt_ph;
      qcnt_ff     <= nxt_qcnt;
      bit_ff      <= nxt_bit;
      tsh_ff      <= nxt_tsh;
      samp_ff     <= nxt_samp;
      bcnt_ff     <= nxt_bcnt;
      sda_oe_n_ff <= nxt_sda_oe_n;
      scl_oe_n_ff <= nxt_scl_oe_n;
      done_ff     <= nxt_done;
      fail_ff     <= nxt_fail;
    end
  end

  // ---------------- sync serial port ----------------
  logic [DW-1:0] deb_cnt_ff, nxt_deb_cnt;
  logic          str_db_ff, nxt_str_db;
  logic          str_prev_ff;
  ssi_state_t    ssi_st_ff, nxt_ssi_st;
  logic [3:0]    scnt_ff, nxt_scnt;
  logic [7:0]    ssh_ff, nxt_ssh;
  logic [7:0]    osh_ff, nxt_osh;
  logic [2:0]    port_ff, nxt_port;
  logic [7:0]    idx_ff, nxt_idx;
  logic          rbit_ff, nxt_rbit;
  logic [5:0]    ccnt_ff, nxt_ccnt;
  ctrl_byte_t    ctx_ff, nxt_ctx;
  logic          take_ff, nxt_take;
  logic          sdo_ff, sdo_oe_n_ff;
  logic          ssi_we;
  logic          rise;
  logic          fall;
  logic          ev_start;
  logic          ev_abort;
  logic [7:0]    rd_val;

  // debounce trades a few clocks of latency per edge for glitch immunity
  always_comb begin
    nxt_deb_cnt = '0;
    nxt_str_db  = str_db_ff;
    if (str_s != str_db_ff) begin
      if (dbo_s || deb_cnt_ff == DW'(DEB_CYC - 1)) begin
        nxt_str_db = str_s;
      end else begin
        nxt_deb_cnt = deb_cnt_ff + 1'b1;
      end
    end
  end

  always_comb begin
    case (ssh_ff[2:0])
      PORT_INDEX: rd_val = idx_ff;
      PORT_DATA:  rd_val = cfg_mem[idx_ff[CFG_AW-1:0]];
      PORT_CTRL:  rd_val = i_ctrl_rx_data;
      default:    rd_val = RD_UNMAPPED;
    endcase
  end

  always_comb begin
    nxt_ssi_st = ssi_st_ff;
    nxt_scnt   = scnt_ff;
    nxt_ssh    = ssh_ff;
    nxt_osh    = osh_ff;
    nxt_port   = port_ff;
    nxt_idx    = idx_ff;
    nxt_rbit   = rbit_ff;
    nxt_ccnt   = ccnt_ff;
    nxt_ctx    = '{valid: 1'b0, last: ctx_ff.last, data: ctx_ff.data};
    nxt_take   = 1'b0;
    ssi_we     = 1'b0;
    rise       = str_db_ff && !str_prev_ff;
    fall       = !str_db_ff && str_prev_ff;
    ev_start   = fall && rbit_ff && !din_s;
    ev_abort   = fall && !rbit_ff && din_s;
    if (rise) begin
      nxt_rbit = din_s;
    end
    if (ev_start) begin
      nxt_ssi_st = SSI_HDR;
      nxt_scnt   = 4'd0;
    end else if (ev_abort && ssi_st_ff != SSI_RDATA) begin
      nxt_ssi_st = SSI_IDLE;
      nxt_ccnt   = 6'd0;
    end else if (fall) begin
      // in read data an abort pattern is just one more shift bit
      nxt_scnt = scnt_ff + 4'd1;
      case (ssi_st_ff)
        SSI_HDR: begin
          nxt_ssh = {ssh_ff[6:0], din_s};
          if (scnt_ff == 4'(SSI_HDR_BITS - 1)) begin
            nxt_scnt = 4'd0;
            nxt_port = ssh_ff[2:0];
            if (ssh_ff[5:3] != id_ff) begin
              nxt_ssi_st = SSI_IDLE;
            end else if (din_s) begin
              nxt_ssi_st = SSI_RDATA;
              nxt_osh    = rd_val;
              nxt_take   = (ssh_ff[2:0] == PORT_CTRL);
            end else begin
              nxt_ssi_st = SSI_WDATA;
            end
          end
        end
        SSI_WDATA: begin
          nxt_ssh = {ssh_ff[6:0], din_s};
          if (scnt_ff == 4'(SSI_DATA_BITS - 1)) begin
            nxt_ssi_st = SSI_WEND;
            nxt_scnt   = 4'd0;
          end
        end
        SSI_WEND: begin
          if (!din_s) begin
            nxt_ssi_st = SSI_IDLE;
          end else if (scnt_ff == 4'(SSI_END_BITS - 1)) begin
            nxt_ssi_st = SSI_IDLE;
            case (port_ff)
              PORT_INDEX: nxt_idx = ssh_ff;
              PORT_DATA:  ssi_we  = 1'b1;
              PORT_CTRL: begin
                nxt_ctx  = '{valid: 1'b1,
                             last: ccnt_ff == 6'(CTRL_FRAME_MAX - 1),
                             data: ssh_ff};
                nxt_ccnt = (ccnt_ff == 6'(CTRL_FRAME_MAX - 1)) ? 6'd0 : ccnt_ff + 6'd1;
              end
              default: nxt_idx = idx_ff;
            endcase
          end
        end
        SSI_RDATA: begin
          nxt_osh = {osh_ff[6:0], 1'b0};
          if (scnt_ff == 4'(SSI_DATA_BITS - 1)) begin
            nxt_ssi_st = SSI_IDLE;
          end
        end
        default: begin
          nxt_ssi_st = SSI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      deb_cnt_ff  <= '0;
      str_db_ff   <= 1'b0;
      str_prev_ff <= 1'b0;
      ssi_st_ff   <= SSI_IDLE;
      scnt_ff     <= 4'd0;
      ssh_ff      <= 8'h00;
      osh_ff      <= 8'h00;
      port_ff     <= PORT_INDEX;
      idx_ff      <= INDEX_RESET;
      rbit_ff     <= 1'b0;
      ccnt_ff     <= 6'd0;
      ctx_ff      <= '0;
      take_ff     <= 1'b0;
      sdo_ff      <= 1'b1;
      sdo_oe_n_ff <= 1'b1;
    end else begin
      deb_cnt_ff  <= nxt_deb_cnt;
      str_db_ff   <= nxt_str_db;
      str_prev_ff <= str_db_ff;
      ssi_st_ff   <= nxt_ssi_st;
      scnt_ff     <= nxt_scnt;
      ssh_ff      <= nxt_ssh;
      osh_ff      <= nxt_osh;
      port_ff     <= nxt_port;
      idx_ff      <= nxt_idx;
      rbit_ff     <= nxt_rbit;
      ccnt_ff     <= nxt_ccnt;
      ctx_ff      <= nxt_ctx;
      take_ff     <= nxt_take;
      sdo_ff      <= (nxt_ssi_st == SSI_RDATA) ? nxt_osh[7] : 1'b1;
      sdo_oe_n_ff <= (nxt_ssi_st != SSI_RDATA);
    end
  end

  // boot load wins a clash with a serial write
  always_ff @(posedge i_clk) begin
    if (boot_we) begin
      cfg_mem[bcnt_ff] <= tsh_ff;
    end else if (ssi_we) begin
      cfg_mem[idx_ff[CFG_AW-1:0]] <= ssh_ff;
    end
    o_cfg_rdata <= cfg_mem[i_cfg_raddr];
  end

  assign o_twi_sda              = 1'b0;
  assign o_twi_scl              = 1'b0;
  assign o_twi_sda_oe_n         = sda_oe_n_ff;
  assign o_twi_scl_oe_n         = scl_oe_n_ff;
  assign o_serial_data_out      = sdo_ff;
  assign o_serial_data_out_oe_n = sdo_oe_n_ff;
  assign o_ctrl_tx              = ctx_ff;
  assign o_ctrl_rx_take         = take_ff;
  assign o_boot_done            = done_ff;
  assign o_boot_fail            = fail_ff;

  // ---------------- checks ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_twi_sda_stable: assert property (
    (twi_st_ff == TWI_BYTE && $past(twi_st_ff) == TWI_BYTE && scl_oe_n_ff && $past(scl_oe_n_ff))
      |-> $stable(sda_oe_n_ff)) else $error("sda moved while scl high");
  chk_twi_start_edge: assert property (
    (twi_st_ff == TWI_START && ph_ff == 2'd2) |=> (!sda_oe_n_ff && scl_oe_n_ff))
    else $error("start not sda low with scl high");
  chk_twi_stop_edge: assert property (
    (twi_st_ff == TWI_STOP && ph_ff == 2'd2) |=> (sda_oe_n_ff && scl_oe_n_ff))
    else $error("stop not both lines released");
  chk_twi_idle_free: assert property (
    (twi_st_ff inside {TWI_IDLE, TWI_DONE} && $past(twi_st_ff) inside {TWI_IDLE, TWI_DONE})
      |-> (sda_oe_n_ff && scl_oe_n_ff)) else $error("idle bus not released");
  chk_twi_nack_stop: assert property (
    (twi_st_ff == TWI_BYTE && tx && bit_ff == 4'd8 && ph_ff == 2'd3 && tick && samp_ff)
      |=> (twi_st_ff == TWI_STOP && fail_ff)) else $error("nack did not stop");
  chk_twi_read_dir: assert property (
    (twi_st_ff == TWI_START && tick && ph_ff == 2'd3 && seq_ff == SEQ_ADDR_RD)
      |=> (tsh_ff == {EEPROM_ADDR, 1'b1})) else $error("read address byte wrong");
  chk_twi_ack_release: assert property (
    (twi_st_ff == TWI_BYTE && tx && bit_ff == 4'd8) |=> sda_oe_n_ff)
    else $error("sda not released in ack slot");
  chk_twi_bit_rate: assert property (
    (twi_st_ff == TWI_BYTE && $past(twi_st_ff) == TWI_BYTE && ph_ff != $past(ph_ff))
      |-> ($past(qcnt_ff) == QW'(QTR_CYC - 1))) else $error("quarter period wrong");
  chk_ssi_start_det: assert property (
    ev_start |=> (ssi_st_ff == SSI_HDR && scnt_ff == 4'd0)) else $error("start missed");
  chk_ssi_abort_write: assert property (
    (ev_abort && ssi_st_ff != SSI_RDATA) |=> ssi_st_ff == SSI_IDLE)
    else $error("abort ignored");
  chk_ssi_read_keeps: assert property (
    (ev_abort && ssi_st_ff == SSI_RDATA && scnt_ff != 4'(SSI_DATA_BITS - 1))
      |=> ssi_st_ff == SSI_RDATA)
    else $error("read aborted after command");
  chk_ssi_out_release: assert property (
    ##1 (ssi_st_ff != SSI_RDATA) |-> sdo_oe_n_ff) else $error("data out driven while not reading");

  cov_boot_done: cover property (twi_st_ff == TWI_STOP ##1 twi_st_ff == TWI_DONE && !fail_ff);
  cov_boot_nack: cover property (fail_ff && twi_st_ff == TWI_DONE);
  cov_ssi_write: cover property (ssi_we);
  cov_ssi_read:  cover property (ssi_st_ff == SSI_RDATA ##1 ssi_st_ff == SSI_IDLE);

endmodule : serial_config_interfaces
